/* hmc_chain.v */
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "hmc_consts.vh"
module hmc_chain #(
    parameter BUF_DEPTH = 16,
    parameter BUF_AW = 4,
    parameter [7:0] FUNC_READ = 8'h04
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire [3:0] av_address_in,
    input wire av_read_in,
    input wire av_write_in,
    input wire [31:0] av_writedata_in,
    output reg [31:0] av_readdata_out,
    output wire av_waitrequest_out,
    input wire [15:0] wake_sel_in,
    output wire [19:0] mem_addr_out,
    output wire mem_read_out,
    output wire mem_write_out,
    output wire [7:0] mem_wdata_out,
    input wire [7:0] mem_rdata_in,
    input wire mem_wait_in,
    input wire [7:0] drv_data_in,
    input wire drv_valid_in,
    output wire drv_ready_out,
    output reg [7:0] drv_func_out,
    output reg host_irq_out
);
    // ***************************************
    // States
    // ***************************************
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_WUB = 4'h1;
    localparam [3:0] S_CCB = 4'h2;
    localparam [3:0] S_BSET = 4'h3;
    localparam [3:0] S_CIB = 4'h4;
    localparam [3:0] S_PB = 4'h5;
    localparam [3:0] S_FILL = 4'h6;
    localparam [3:0] S_DMA = 4'h7;
    localparam [3:0] S_SEMR = 4'h8;
    localparam [3:0] S_STAT = 4'h9;
    localparam [3:0] S_SEMW = 4'ha;
    localparam [3:0] S_BCLR = 4'hb;

    reg [3:0] state_reg;
    reg pend_reg;
    reg [4:0] idx_reg;
    reg [31:0] word_reg;
    reg linked_reg;
    reg in_reset_reg;
    reg err_reg;
    reg [1:0] last_cmd_reg;
    reg [19:0] wub_reg;
    reg [19:0] ccb_reg;
    reg [19:0] cib_reg;
    reg [19:0] pb_reg;
    reg [31:0] done_cnt_reg;
    reg [BUF_AW:0] fill_reg;
    reg [BUF_AW:0] dma_reg;
    reg ack_reg;
    reg [7:0] pram [0:29];
    reg [7:0] dbuf [0:BUF_DEPTH-1];

    wire wake_wr;
    wire mem_state;
    wire go;
    wire mp_busy;
    wire mp_done;
    wire [7:0] mp_rdata;
    wire [31:0] word_next;
    wire [31:0] req_cnt;
    wire [31:0] buf_word;
    wire [19:0] buf_addr;
    wire last_fill;
    reg [19:0] addr_mux;
    reg we_mux;
    reg [7:0] wdata_mux;

    // Segment in the upper word, offset in the lower word
    function [19:0] seg_off;
        input [31:0] w;
        begin
            seg_off = {w[31:16], 4'h0} + {4'h0, w[15:0]};
        end
    endfunction

    // ***************************************
    // Avalon slave
    // ***************************************
    // Fixed one wait state: answer at the second edge of a request
    assign av_waitrequest_out = (av_read_in | av_write_in) & ~ack_reg;
    // Command acts at the edge where the master sees waitrequest low
    assign wake_wr = av_write_in & ack_reg & (av_address_in == `HMC_OFS_WAKE);

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            ack_reg <= 1'b0;
            av_readdata_out <= 32'h00000000;
        end else begin
            ack_reg <= (av_read_in | av_write_in) & ~ack_reg;
            if (av_read_in & ~ack_reg) begin
                case (av_address_in)
                    `HMC_OFS_WAKE: av_readdata_out <= {30'h00000000, last_cmd_reg};
                    `HMC_OFS_STAT: begin
                        av_readdata_out <= 32'h00000000;
                        av_readdata_out[`HMC_ST_BUSY] <= (state_reg != S_IDLE);
                        av_readdata_out[`HMC_ST_LINK] <= linked_reg;
                        av_readdata_out[`HMC_ST_IRQ] <= host_irq_out;
                        av_readdata_out[`HMC_ST_RST] <= in_reset_reg;
                        av_readdata_out[`HMC_ST_STATE_LO+3:`HMC_ST_STATE_LO] <= state_reg;
                    end
                    `HMC_OFS_CCBA: av_readdata_out <= {12'h000, ccb_reg};
                    `HMC_OFS_PBA: av_readdata_out <= {12'h000, pb_reg};
                    default: av_readdata_out <= 32'h00000000;
                endcase
            end
        end
    end

    // ***************************************
    // Memory access mux
    // ***************************************
    assign word_next = {mp_rdata, word_reg[31:8]};
    assign req_cnt = {pram[`HMC_PB_REQ+3], pram[`HMC_PB_REQ+2],
                      pram[`HMC_PB_REQ+1], pram[`HMC_PB_REQ]};
    assign buf_word = {pram[`HMC_PB_BUF+3], pram[`HMC_PB_BUF+2],
                       pram[`HMC_PB_BUF+1], pram[`HMC_PB_BUF]};
    assign buf_addr = seg_off(buf_word);
    assign mem_state = (state_reg != S_IDLE) && (state_reg != S_FILL);
    assign go = mem_state & ~pend_reg & ~mp_busy;
    assign drv_ready_out = (state_reg == S_FILL);
    assign last_fill = (fill_reg == BUF_DEPTH - 1) ||
                       (done_cnt_reg + {{(31-BUF_AW){1'b0}}, fill_reg} + 32'h1 == req_cnt);

    always @* begin
        addr_mux = 20'h00000;
        we_mux = 1'b0;
        wdata_mux = 8'h00;
        case (state_reg)
            S_WUB: addr_mux = wub_reg + `HMC_WUB_CCBP + {15'h0000, idx_reg};
            S_CCB: addr_mux = ccb_reg + {15'h0000, idx_reg};
            // Pointer is re-read every start whose program is not refused so a moved parameter block is seen
            S_CIB: addr_mux = cib_reg + `HMC_CIB_PBP + {15'h0000, idx_reg};
            S_PB: addr_mux = pb_reg + {15'h0000, idx_reg};
            S_BSET: begin
                addr_mux = ccb_reg + `HMC_CCB_BUSY;
                we_mux = 1'b1;
                wdata_mux = `HMC_BUSY_SET;
            end
            S_DMA: begin
                addr_mux = buf_addr + done_cnt_reg[19:0];
                we_mux = 1'b1;
                wdata_mux = dbuf[dma_reg[BUF_AW-1:0]];
            end
            S_SEMR: addr_mux = cib_reg + `HMC_CIB_SEM;
            S_STAT: begin
                addr_mux = cib_reg + `HMC_CIB_STAT;
                we_mux = 1'b1;
                wdata_mux = err_reg ? `HMC_STAT_ERR : `HMC_STAT_OK;
            end
            S_SEMW: begin
                addr_mux = cib_reg + `HMC_CIB_SEM;
                we_mux = 1'b1;
                wdata_mux = `HMC_SEM_POSTED;
            end
            S_BCLR: begin
                addr_mux = ccb_reg + `HMC_CCB_BUSY;
                we_mux = 1'b1;
                wdata_mux = `HMC_BUSY_CLR;
            end
            default: addr_mux = 20'h00000;
        endcase
    end

    hmc_mem_port u_mem (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .go_in(go),
        .we_in(we_mux),
        .addr_in(addr_mux),
        .wdata_in(wdata_mux),
        .busy_out(mp_busy),
        .done_out(mp_done),
        .rdata_out(mp_rdata),
        .mem_addr_out(mem_addr_out),
        .mem_read_out(mem_read_out),
        .mem_write_out(mem_write_out),
        .mem_wdata_out(mem_wdata_out),
        .mem_rdata_in(mem_rdata_in),
        .mem_wait_in(mem_wait_in)
    );

    // ***************************************
    // Local RAM
    // ***************************************
    always @(posedge clk_in) begin
        if (state_reg == S_PB && pend_reg && mp_done) begin
            pram[idx_reg] <= mp_rdata;
        end
        if (state_reg == S_FILL && drv_valid_in) begin
            dbuf[fill_reg[BUF_AW-1:0]] <= drv_data_in;
        end
    end

    // ***************************************
    // Command chain sequencer
    // ***************************************
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg <= S_IDLE;
            pend_reg <= 1'b0;
            idx_reg <= 5'h00;
            word_reg <= 32'h00000000;
            linked_reg <= 1'b0;
            in_reset_reg <= 1'b0;
            err_reg <= 1'b0;
            last_cmd_reg <= 2'h0;
            wub_reg <= 20'h00000;
            ccb_reg <= 20'h00000;
            cib_reg <= 20'h00000;
            pb_reg <= 20'h00000;
            done_cnt_reg <= 32'h00000000;
            fill_reg <= {(BUF_AW+1){1'b0}};
            dma_reg <= {(BUF_AW+1){1'b0}};
            drv_func_out <= 8'h00;
            host_irq_out <= 1'b0;
        end else if (wake_wr && av_writedata_in[1:0] == `HMC_WK_RESET) begin
            // Board reset: abandon work and drop the link
            last_cmd_reg <= `HMC_WK_RESET;
            in_reset_reg <= 1'b1;
            linked_reg <= 1'b0;
            host_irq_out <= 1'b0;
            state_reg <= S_IDLE;
            pend_reg <= 1'b0;
        end else begin
            if (go) begin
                pend_reg <= 1'b1;
            end
            if (wake_wr) begin
                last_cmd_reg <= av_writedata_in[1:0];
                if (av_writedata_in[1:0] == `HMC_WK_CLEAR) begin
                    host_irq_out <= 1'b0;
                    in_reset_reg <= 1'b0;
                end
            end
            case (state_reg)
                S_IDLE: begin
                    if (wake_wr && av_writedata_in[1:0] == `HMC_WK_START && !in_reset_reg) begin
                        idx_reg <= 5'h00;
                        err_reg <= 1'b0;
                        if (linked_reg) begin
                            state_reg <= S_CCB;
                        end else begin
                            wub_reg <= {wake_sel_in, 4'h0};
                            state_reg <= S_WUB;
                        end
                    end
                end
                S_WUB: begin
                    if (pend_reg && mp_done) begin
                        pend_reg <= 1'b0;
                        word_reg <= word_next;
                        idx_reg <= idx_reg + 5'h01;
                        if (idx_reg == 5'h03) begin
                            ccb_reg <= seg_off(word_next);
                            idx_reg <= 5'h00;
                            state_reg <= S_CCB;
                        end
                    end
                end
                S_CCB: begin
                    if (pend_reg && mp_done) begin
                        pend_reg <= 1'b0;
                        word_reg <= word_next;
                        idx_reg <= idx_reg + 5'h01;
                        // Only the ROM program is carried; a host program is refused
                        if (idx_reg == 5'h00 && mp_rdata != `HMC_CTL_ROM) begin
                            err_reg <= 1'b1;
                        end
                        if (idx_reg == 5'h05) begin
                            idx_reg <= 5'h00;
                            if (!linked_reg) begin
                                // Pointer names byte 4 of the invocation block
                                cib_reg <= seg_off(word_next) - `HMC_CIB_BACK;
                            end
                            if (err_reg) begin
                                state_reg <= S_SEMR;
                            end else if (linked_reg) begin
                                state_reg <= S_BSET;
                            end else begin
                                state_reg <= S_CIB;
                            end
                        end
                    end
                end
                S_BSET: begin
                    if (pend_reg && mp_done) begin
                        pend_reg <= 1'b0;
                        state_reg <= S_CIB;
                    end
                end
                S_CIB: begin
                    // Byte 2 is left alone for host interlocks
                    if (pend_reg && mp_done) begin
                        pend_reg <= 1'b0;
                        word_reg <= word_next;
                        idx_reg <= idx_reg + 5'h01;
                        if (idx_reg == 5'h03) begin
                            pb_reg <= seg_off(word_next);
                            idx_reg <= 5'h00;
                            state_reg <= S_PB;
                        end
                    end
                end
                S_PB: begin
                    if (pend_reg && mp_done) begin
                        pend_reg <= 1'b0;
                        idx_reg <= idx_reg + 5'h01;
                        if (idx_reg == `HMC_PB_LEN - 5'h01) begin
                            drv_func_out <= pram[`HMC_PB_FUNC];
                            done_cnt_reg <= 32'h00000000;
                            fill_reg <= {(BUF_AW+1){1'b0}};
                            if (pram[`HMC_PB_FUNC] == FUNC_READ && req_cnt != 32'h0) begin
                                state_reg <= S_FILL;
                            end else begin
                                state_reg <= S_SEMR;
                            end
                        end
                    end
                end
                S_FILL: begin
                    if (drv_valid_in) begin
                        fill_reg <= fill_reg + 1'b1;
                        if (last_fill) begin
                            dma_reg <= {(BUF_AW+1){1'b0}};
                            state_reg <= S_DMA;
                        end
                    end
                end
                S_DMA: begin
                    if (pend_reg && mp_done) begin
                        pend_reg <= 1'b0;
                        done_cnt_reg <= done_cnt_reg + 32'h1;
                        dma_reg <= dma_reg + 1'b1;
                        if (dma_reg + 1'b1 == fill_reg) begin
                            fill_reg <= {(BUF_AW+1){1'b0}};
                            if (done_cnt_reg + 32'h1 == req_cnt) begin
                                state_reg <= S_SEMR;
                            end else begin
                                state_reg <= S_FILL;
                            end
                        end
                    end
                end
                S_SEMR: begin
                    // Poll until the host has taken the previous status
                    if (pend_reg && mp_done) begin
                        pend_reg <= 1'b0;
                        if (mp_rdata == `HMC_SEM_READ) begin
                            state_reg <= S_STAT;
                        end
                    end
                end
                S_STAT: begin
                    if (pend_reg && mp_done) begin
                        pend_reg <= 1'b0;
                        state_reg <= S_SEMW;
                    end
                end
                S_SEMW: begin
                    if (pend_reg && mp_done) begin
                        pend_reg <= 1'b0;
                        state_reg <= S_BCLR;
                    end
                end
                S_BCLR: begin
                    if (pend_reg && mp_done) begin
                        pend_reg <= 1'b0;
                        linked_reg <= 1'b1;
                        host_irq_out <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule

/* hmc_chain_assertions.sv */
`timescale 1ns/1ps
// ****************
// Port protocol checks
// ****************
module hmc_chain_checker (
    input wire clk_in,
    input wire rst_n_in,
    input wire [3:0] av_address_in,
    input wire av_read_in,
    input wire av_write_in,
    input wire [31:0] av_writedata_in,
    input wire av_waitrequest_out,
    input wire [15:0] wake_sel_in,
    input wire [19:0] mem_addr_out,
    input wire mem_read_out,
    input wire mem_write_out,
    input wire [7:0] mem_wdata_out,
    input wire mem_wait_in,
    input wire drv_ready_out,
    input wire host_irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    reg seen_reg;
    always @(posedge clk_in) seen_reg <= rst_n_in && (seen_reg || mem_read_out);
    sequence req_taken;
        (av_read_in || av_write_in) && av_waitrequest_out;
    endsequence
    sequence clr_taken;
        av_write_in && !av_waitrequest_out && av_address_in == 4'h0 && av_writedata_in[1:0] == 2'h0;
    endsequence
    one_wait_a: assert property (req_taken |=> !av_waitrequest_out)
        else $error("slave wait state count wrong");
    clear_irq_a: assert property (clr_taken |=> !host_irq_out)
        else $error("clear code left interrupt high");
    wake_addr_a: assert property (mem_read_out && !seen_reg |-> mem_addr_out == {wake_sel_in, 4'h0} + 20'h2)
        else $error("first fetch not at wake block");
    dir_excl_a: assert property (!(mem_read_out && mem_write_out))
        else $error("memory read and write together");
    rd_hold_a: assert property (mem_read_out && mem_wait_in |=> mem_read_out && $stable(mem_addr_out))
        else $error("memory read dropped while waiting");
    wr_hold_a: assert property (mem_write_out && mem_wait_in |=> mem_write_out && $stable({mem_addr_out, mem_wdata_out}))
        else $error("memory write changed while waiting");
    fill_quiet_a: assert property (drv_ready_out |-> !mem_write_out)
        else $error("memory write during buffer fill");
    reset_clean_a: assert property ($rose(rst_n_in) |-> !host_irq_out && !mem_read_out && !mem_write_out)
        else $error("outputs active after reset");
endmodule
bind hmc_chain hmc_chain_checker u_chk (.*);

/* hmc_consts.vh */
`ifndef HMC_CONSTS_VH
`define HMC_CONSTS_VH
// ***************************************
// Register offsets (byte addresses)
// ***************************************
`define HMC_OFS_WAKE 4'h0
`define HMC_OFS_STAT 4'h4
`define HMC_OFS_CCBA 4'h8
`define HMC_OFS_PBA 4'hc
// ***************************************
// Status register fields
// ***************************************
`define HMC_ST_BUSY 0
`define HMC_ST_LINK 1
`define HMC_ST_IRQ 2
`define HMC_ST_RST 3
`define HMC_ST_STATE_LO 8
// ***************************************
// Wake-up port codes
// ***************************************
`define HMC_WK_CLEAR 2'h0
`define HMC_WK_START 2'h1
`define HMC_WK_RESET 2'h2
// ***************************************
// Block byte offsets
// ***************************************
`define HMC_WUB_CCBP 20'h00002
`define HMC_CCB_BUSY 20'h00001
`define HMC_CIB_BACK 20'h00004
`define HMC_CIB_STAT 20'h00001
`define HMC_CIB_SEM 20'h00003
`define HMC_CIB_PBP 20'h00008
`define HMC_PB_LEN 5'h1e
`define HMC_PB_FUNC 11
`define HMC_PB_BUF 18
`define HMC_PB_REQ 22
// ***************************************
// Byte codes
// ***************************************
`define HMC_CTL_ROM 8'h01
`define HMC_CTL_HOST 8'h03
`define HMC_BUSY_SET 8'hff
`define HMC_BUSY_CLR 8'h00
`define HMC_SEM_POSTED 8'hff
`define HMC_SEM_READ 8'h00
`define HMC_STAT_OK 8'h00
`define HMC_STAT_ERR 8'h01
`endif

/* hmc_host_mem.sv */
`timescale 1ns/1ps
// ****************
// Host memory with settable answer latency
// ****************
module hmc_host_mem (
    input wire clk_in,
    input wire [19:0] mem_addr_in,
    input wire mem_read_in,
    input wire mem_write_in,
    input wire [7:0] mem_wdata_in,
    input wire [3:0] lat_in,
    output reg [7:0] mem_rdata_out,
    output reg mem_wait_out
);
    // Blocks stay where the host built them
    reg [7:0] mem [0:1048575];
    reg [3:0] cnt_reg;
    initial begin
        mem_wait_out = 1'b1;
        mem_rdata_out = 8'h00;
        cnt_reg = 4'h0;
    end
    always @(posedge clk_in) begin
        mem_wait_out <= 1'b1;
        // Stale data flips so a late sample is caught
        mem_rdata_out <= ~mem_rdata_out;
        cnt_reg <= 4'h0;
        if ((mem_read_in || mem_write_in) && mem_wait_out) begin
            if (cnt_reg >= lat_in) begin
                mem_wait_out <= 1'b0;
                mem_rdata_out <= mem[mem_addr_in];
                if (mem_write_in) mem[mem_addr_in] <= mem_wdata_in;
            end else cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule

/* hmc_mem_port.v */
`timescale 1ns/1ps
// One byte access on the host memory bus, Avalon style master
module hmc_mem_port (
    input wire clk_in,
    input wire rst_n_in,
    input wire go_in,
    input wire we_in,
    input wire [19:0] addr_in,
    input wire [7:0] wdata_in,
    output wire busy_out,
    output reg done_out,
    output reg [7:0] rdata_out,
    output reg [19:0] mem_addr_out,
    output reg mem_read_out,
    output reg mem_write_out,
    output reg [7:0] mem_wdata_out,
    input wire [7:0] mem_rdata_in,
    input wire mem_wait_in
);
    wire active;

    assign active = mem_read_out | mem_write_out;
    assign busy_out = active;

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            mem_addr_out <= 20'h00000;
            mem_read_out <= 1'b0;
            mem_write_out <= 1'b0;
            mem_wdata_out <= 8'h00;
            rdata_out <= 8'h00;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (active) begin
                // Request held until the slave drops waitrequest
                if (!mem_wait_in) begin
                    mem_read_out <= 1'b0;
                    mem_write_out <= 1'b0;
                    done_out <= 1'b1;
                    if (mem_read_out) begin
                        rdata_out <= mem_rdata_in;
                    end
                end
            end else if (go_in) begin
                mem_addr_out <= addr_in;
                mem_wdata_out <= wdata_in;
                mem_read_out <= ~we_in;
                mem_write_out <= we_in;
            end
        end
    end
endmodule

/* tb_host_memory_command_block_chain.sv */
`timescale 1ns/1ps
// ****************
// Chain bench
// ****************
module tb_host_memory_command_block_chain;
    localparam [7:0] FN = 8'h04;
    reg clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg [3:0] av_address_in = 4'h0;
    reg av_read_in = 1'b0;
    reg av_write_in = 1'b0;
    reg [31:0] av_writedata_in = 32'h0;
    reg [15:0] wake_sel_in = 16'h0100;
    reg [7:0] drv_data_in = 8'h30;
    reg drv_valid_in = 1'b0;
    reg [3:0] lat = 4'h0;
    reg take = 1'b0;
    reg busy_seen = 1'b0;
    integer polls = 0;
    reg [31:0] rq;
    wire [31:0] av_readdata_out;
    wire [19:0] mem_addr_out;
    wire [7:0] mem_wdata_out, mem_rdata_in, drv_func_out;
    wire av_waitrequest_out, mem_read_out, mem_write_out, mem_wait_in, drv_ready_out, host_irq_out;
    integer err_total = 0, checked = 0, n, i;
    always #50 clk_in = ~clk_in;
    hmc_chain #(.FUNC_READ(FN)) dut (.*);
    hmc_host_mem host (.clk_in(clk_in), .mem_addr_in(mem_addr_out), .mem_read_in(mem_read_out),
        .mem_write_in(mem_write_out), .mem_wdata_in(mem_wdata_out), .lat_in(lat),
        .mem_rdata_out(mem_rdata_in), .mem_wait_out(mem_wait_in));
    always @(negedge clk_in) begin
        take = drv_ready_out && drv_valid_in;
        if (mem_write_out && !mem_wait_in && mem_addr_out == 20'h01101 && mem_wdata_out == 8'hff)
            busy_seen = 1'b1;
        if (mem_read_out && !mem_wait_in && mem_addr_out == 20'h01203) polls = polls + 1;
    end
    // Drive side stalls every other cycle
    always @(posedge clk_in) begin
        drv_valid_in <= ~drv_valid_in;
        if (take) drv_data_in <= drv_data_in + 8'h1;
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task av(input w, input [3:0] a, input [31:0] d);
        begin
            @(posedge clk_in);
            av_address_in <= a;
            av_read_in <= !w;
            av_write_in <= w;
            av_writedata_in <= d;
            n = 0;
            @(posedge clk_in);
            while (av_waitrequest_out !== 1'b0 && n < 50) begin
                n = n + 1;
                @(posedge clk_in);
            end
            if (n >= 50) err_total = err_total + 1;
            rq = av_readdata_out;
            av_read_in <= 1'b0;
            av_write_in <= 1'b0;
        end
    endtask
    task wait_irq;
        begin
            n = 0;
            while (host_irq_out !== 1'b1 && n < 5000) begin
                n = n + 1;
                @(negedge clk_in);
            end
        end
    endtask
    task ptr(input [19:0] a, input [15:0] off, input [15:0] seg);
        begin
            host.mem[a] = off[7:0];
            host.mem[a + 1] = off[15:8];
            host.mem[a + 2] = seg[7:0];
            host.mem[a + 3] = seg[15:8];
        end
    endtask
    task build;
        begin
            for (i = 0; i < 20'h03000; i = i + 1) host.mem[i] = 8'h00;
            host.mem[20'h01000] = 8'h01;
            ptr(20'h01002, 16'h0, 16'h0110);
            host.mem[20'h01100] = 8'h01;
            ptr(20'h01102, 16'h4, 16'h0120);
            host.mem[20'h01108] = 8'h01;
            host.mem[20'h0110c] = 8'h0e;
            host.mem[20'h0110e] = 8'h04;
            host.mem[20'h01202] = 8'h5a;
            ptr(20'h01208, 16'h0, 16'h0130);
            host.mem[20'h0130b] = FN;
            ptr(20'h01312, 16'h0, 16'h0200);
            host.mem[20'h01316] = 8'd20;
        end
    endtask
    task cold_start;
        begin
            av(1'b1, 4'h0, 32'h1);
            wait_irq;
            chk(host_irq_out, 1'b1);
            chk(host.mem[20'h01201], 8'h00);
            chk(host.mem[20'h01203], 8'hff);
            chk(busy_seen, 1'b0);
            chk(drv_func_out, FN);
            chk(host.mem[20'h01202], 8'h5a);
            for (i = 0; i < 20; i = i + 1) chk(host.mem[20'h02000 + i], 8'h30 + i);
            av(1'b0, 4'h8, 32'h0);
            chk(rq[19:0], 20'h01100);
            av(1'b0, 4'h2, 32'h0);
            chk(rq, 32'h0);
        end
    endtask
    task linked_start;
        begin
            av(1'b1, 4'h0, 32'hfc);
            @(negedge clk_in);
            chk(host_irq_out, 1'b0);
            lat = 4'h3;
            host.mem[20'h01203] = 8'hff;
            host.mem[20'h01004] = 8'h50;
            ptr(20'h01208, 16'h0, 16'h0140);
            host.mem[20'h0140b] = 8'h07;
            av(1'b1, 4'h0, 32'h1);
            i = polls + 2;
            n = 0;
            while (polls < i && n < 5000) begin
                n = n + 1;
                @(negedge clk_in);
            end
            chk(polls >= i, 1'b1);
            chk(host_irq_out, 1'b0);
            chk(host.mem[20'h01101], 8'hff);
            host.mem[20'h01203] = 8'h00;
            wait_irq;
            chk(host_irq_out, 1'b1);
            chk(host.mem[20'h01201], 8'h00);
            chk(drv_func_out, 8'h07);
            chk(busy_seen, 1'b1);
            chk(host.mem[20'h01101], 8'h00);
        end
    endtask
    task soft_reset;
        begin
            av(1'b1, 4'h0, 32'h2);
            av(1'b0, 4'h4, 32'h0);
            chk(rq[3:2], 2'b10);
            av(1'b1, 4'h0, 32'h1);
            av(1'b0, 4'h4, 32'h0);
            chk(rq[0], 1'b0);
            av(1'b1, 4'h0, 32'h0);
            av(1'b0, 4'h4, 32'h0);
            chk(rq[3:1], 3'b000);
            // Relink after reset with a host-program request, which is refused
            host.mem[20'h01004] = 8'h10;
            host.mem[20'h01100] = 8'h03;
            host.mem[20'h01203] = 8'h00;
            av(1'b1, 4'h0, 32'h1);
            wait_irq;
            chk(host_irq_out, 1'b1);
            chk(host.mem[20'h01201], 8'h01);
            av(1'b0, 4'h4, 32'h0);
            chk(rq[1], 1'b1);
        end
    endtask
    task final_report;
        begin
            $display("mismatches %0d of %0d checks", err_total, checked);
            if (err_total == 0 && checked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        build;
        cold_start;
        linked_start;
        soft_reset;
        final_report;
    end
    initial begin
        #3000000;
        err_total = err_total + 1;
        final_report;
    end
endmodule
